// ===== mem_map_defines.vh
// Offsets, field positions, reset values and timing counts for the memory map and bootstrap block
`ifndef MEM_MAP_DEFINES_VH
`define MEM_MAP_DEFINES_VH

// Register byte offsets on the AHB-Lite slave
`define OFF_MODE          8'h00
`define OFF_STATUS        8'h04
`define OFF_HOST_DATA     8'h08
`define OFF_HOST_CTRL     8'h0C
`define OFF_BOOT_CTRL     8'h10
`define OFF_EXT_DATA      8'h14

// Operating mode register fields
`define MODE_LOW_BIT      0
`define MODE_HIGH_BIT     1
`define DROM_EN_BIT       2
`define MODE_RESET        3'h0

// Mode encodings
`define MODE_SINGLE       2'h0
`define MODE_BOOT         2'h1
`define MODE_EXPANDED     2'h2
`define MODE_DEVELOP      2'h3

// Address map
`define XY_RAM_TOP        16'h00FF
`define XY_ROM_BASE       16'h0100
`define XY_ROM_TOP        16'h01FF
`define X_PERIPH_BASE     16'hFFC0
`define P_VECTOR_TOP      16'h003F
`define P_RAM_TOP         16'h01FF
`define P_BOOT_SELECT     16'hC000
`define P_EXT_LAST        16'hC5FF
`define P_WORD_LAST       9'h1FF
`define RESET_VEC_LOW     16'h0000
`define RESET_VEC_EXP     16'hE000

// Remap delay: one single-cycle instruction and a short jump, in core clock cycles at two per instruction
`define REMAP_INSNS       2
`define CYCLES_PER_INSN   2
`define REMAP_CYCLES      (`REMAP_INSNS * `CYCLES_PER_INSN)

`endif

// ===== boot_byte_packer.v
// Packs three loader bytes into one 24-bit program word in a selectable order
`timescale 1ns/1ps
module boot_byte_packer (
	// Clock and reset
	input  wire        clk_in,
	input  wire        resetn_in,
	// Byte stream
	input  wire        clear_in,
	input  wire        high_first_in,
	input  wire        byte_valid_in,
	input  wire [7:0]  byte_in,
	// Word out
	output reg         word_valid_out,
	output reg  [23:0] word_out
);

	reg  [1:0]  count_reg;
	reg  [23:0] acc_reg;
	wire [23:0] acc_next;

	// Low-first puts byte at 8*count; high-first shifts in from the bottom
	assign acc_next = high_first_in ? {acc_reg[15:0], byte_in} :
		(count_reg == 2'h0) ? {16'h0000, byte_in} :
		(count_reg == 2'h1) ? {8'h00, byte_in, acc_reg[7:0]} :
		{byte_in, acc_reg[15:0]};

	// Byte counter; a word issues only after the third byte
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_reg      <= 2'h0;
			acc_reg        <= 24'h000000;
			word_valid_out <= 1'b0;
			word_out       <= 24'h000000;
		end else begin
			word_valid_out <= 1'b0;
			if (clear_in) begin
				count_reg <= 2'h0;
			end else if (byte_valid_in) begin
				acc_reg <= acc_next;
				if (count_reg == 2'h2) begin
					count_reg      <= 2'h0;
					word_valid_out <= 1'b1; // RULE22
					word_out       <= acc_next;
				end else begin
					count_reg <= count_reg + 2'h1;
				end
			end
		end
	end

endmodule // boot_byte_packer

// ===== memory_map_mode_bootstrap.v
// Memory map decode, operating mode control and bootstrap loader
// What this block does
// RULE1: X RAM decodes at X 0..255; X space is 16 bits, expandable off-chip.
// RULE2: X ROM hits X 256..511 only while data ROM enable is one.
// RULE3: Top 64 X addresses hit peripherals and never go external.
// RULE4: Y RAM at Y 0..255; Y ROM at 256..511 when enabled.
// RULE5: 512-word program RAM enabled by mode; else external or boot ROM.
// RULE6: Lowest 64 program addresses are vectors; program space expands to 64K.
// RULE7: 32-word boot ROM active only in mode 1, reached only by bootstrap.
// RULE8: Mode pins sampled at reset release, then serve as interrupt requests.
// RULE9: Mode 0 single-chip, 1 bootstrap, 2 expanded, 3 development.
// RULE10: Software mode write remaps without reset, done after one no-op; here the remap waits REMAP_CYCLES, one instruction and a jump.
// RULE11: Software disables interrupts before and puts a no-op after.
// RULE12: Modes 0 and 2 map all RAM; reset vector 0000 or E000.
// RULE13: Mode 3 sends all program accesses external; reset vector 0000.
// RULE14: Boot mode reads boot ROM on bits 4..0; writes go to RAM up to 01FF, external above.
// RULE15: Bootstrap reads bit 23 of C000: zero host load, one byte memory.
// RULE16: Bytes C000..C5FF, low mid high, fill program words 0..1FF.
// RULE17: Host writes high, mid, low bytes per word, words 0..511.
// RULE18: Host flag zero ends host load early; execute from address 0.
// RULE19: Writing mode 2 ends bootstrap after one instruction and a jump.
// RULE20: Writing mode 1 maps boot ROM in after the same delay.
// RULE21: After loading, switch to single-chip and execute from 0000.
// RULE22: Host load waits for each byte and writes whole words only.
`timescale 1ns/1ps
`include "mem_map_defines.vh"
module memory_map_mode_bootstrap (
	// Clock and reset
	input  wire        clk_in,
	input  wire        resetn_in,
	// AHB-Lite slave
	input  wire        hsel_in,
	input  wire [31:0] haddr_in,
	input  wire [1:0]  htrans_in,
	input  wire        hwrite_in,
	input  wire [2:0]  hsize_in,
	input  wire [31:0] hwdata_in,
	input  wire        hready_in,
	output reg  [31:0] hrdata_out,
	output reg         hreadyout_out,
	output reg         hresp_out,
	// Mode pins, shared with interrupt requests
	input  wire        mode_pin_low_in,
	input  wire        mode_pin_high_in,
	output reg         interrupt_request_a_out,
	output reg         interrupt_request_b_out,
	// Core address buses
	input  wire [15:0] x_address_bus_in,
	input  wire [15:0] y_address_bus_in,
	input  wire [15:0] program_address_bus_in,
	input  wire        program_write_in,
	// Decode results
	output reg  [2:0]  x_select_out,
	output reg  [1:0]  y_select_out,
	output reg  [2:0]  p_select_out,
	output reg  [4:0]  boot_rom_addr_out,
	output reg  [15:0] reset_vector_out,
	// Program RAM write port from the loader
	output reg         pram_we_out,
	output reg  [8:0]  pram_addr_out,
	output reg  [23:0] pram_data_out,
	// Core restart request after load
	output reg         core_restart_out
);

	// Decode codes: X/Y 0 ram,1 rom,2 periph,3 external; P 0 ram,1 boot,2 external
	localparam [2:0] XS_RAM = 3'h0, XS_ROM = 3'h1, XS_PER = 3'h2, XS_EXT = 3'h3;
	localparam [2:0] PS_RAM = 3'h0, PS_BOOT = 3'h1, PS_EXT = 3'h2;

	// Loader states, one-hot
	localparam [5:0] ST_IDLE = 6'h01, ST_PROBE = 6'h02, ST_EXT = 6'h04;
	localparam [5:0] ST_HOST = 6'h08, ST_DONE = 6'h10, ST_WAIT = 6'h20;

	reg        pin_low_s1_reg, pin_low_s2_reg, pin_high_s1_reg, pin_high_s2_reg;
	reg        strap_done_reg;
	reg  [1:0] mode_reg;
	reg  [1:0] map_mode_reg;
	reg  [1:0] pend_mode_reg;
	reg        drom_en_reg;
	reg  [3:0] remap_cnt_reg;
	reg        remap_pend_reg;
	reg  [5:0] state_reg;
	reg        host_sel_reg;
	reg  [15:0] ext_addr_reg;
	reg  [8:0] word_cnt_reg;
	reg        ext_req_reg;
	reg        host_flag_zero_reg;
	reg        host_byte_valid_reg;
	reg  [7:0] host_byte_reg;
	reg        ext_byte_valid_reg;
	reg  [7:0] ext_byte_reg;
	reg        wr_pend_reg;
	reg  [7:0] addr_reg;
	reg        boot_ok_reg;

	wire       word_valid;
	wire [23:0] word_data;
	wire       loading;
	wire       bus_take;
	wire       wr_mode, wr_host, wr_hctl, wr_ext;

	// Remap delay in core cycles, at least one, cut to the counter width
	localparam integer REMAP_CYCLES_INT = (`REMAP_CYCLES < 1) ? 1 : `REMAP_CYCLES;
	localparam [3:0]   REMAP_COUNT      = REMAP_CYCLES_INT[3:0];

	assign loading  = (state_reg == ST_EXT) || (state_reg == ST_HOST);
	assign bus_take = hsel_in && hready_in && htrans_in[1];
	assign wr_mode  = wr_pend_reg && (addr_reg == `OFF_MODE);
	assign wr_host  = wr_pend_reg && (addr_reg == `OFF_HOST_DATA);
	assign wr_hctl  = wr_pend_reg && (addr_reg == `OFF_HOST_CTRL);
	assign wr_ext   = wr_pend_reg && (addr_reg == `OFF_EXT_DATA);

	// Mode pin synchronisers; no reset, so the strap sees settled pins at release
	always @(posedge clk_in) begin
		pin_low_s1_reg  <= mode_pin_low_in;
		pin_low_s2_reg  <= pin_low_s1_reg;
		pin_high_s1_reg <= mode_pin_high_in;
		pin_high_s2_reg <= pin_high_s1_reg;
	end

	// After the strap is taken, pins serve only as interrupt requests
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			interrupt_request_a_out <= 1'b0;
			interrupt_request_b_out <= 1'b0;
		end else begin
			interrupt_request_a_out <= strap_done_reg & pin_low_s2_reg; // RULE8
			interrupt_request_b_out <= strap_done_reg & pin_high_s2_reg; // RULE8
		end
	end

	// AHB address phase capture
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			wr_pend_reg <= bus_take & hwrite_in;
			if (bus_take) begin
				addr_reg <= haddr_in[7:0];
			end
		end
	end

	// AHB read data and response: zero wait, always OKAY
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hrdata_out    <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (bus_take && !hwrite_in) begin
				case (haddr_in[7:0])
				`OFF_MODE:      hrdata_out <= {29'h0, drom_en_reg, mode_reg};
				`OFF_STATUS:    hrdata_out <= {8'h00, word_cnt_reg, 5'h00, boot_ok_reg,
					host_sel_reg, map_mode_reg, state_reg};
				`OFF_HOST_CTRL: hrdata_out <= {31'h0, host_flag_zero_reg};
				`OFF_BOOT_CTRL: hrdata_out <= {16'h0000, ext_addr_reg};
				`OFF_EXT_DATA:  hrdata_out <= {31'h0, ext_req_reg};
				default:        hrdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	// Mode register: strap at release, software writes, loader handover
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			strap_done_reg <= 1'b0;
			mode_reg       <= `MODE_SINGLE;
			drom_en_reg    <= 1'b0;
		end else begin
			if (!strap_done_reg) begin
				strap_done_reg <= 1'b1;
				mode_reg       <= {pin_high_s2_reg, pin_low_s2_reg}; // RULE8 RULE9
			end else if (state_reg == ST_DONE) begin
				mode_reg <= `MODE_SINGLE; // RULE21
			end else if (wr_mode) begin
				mode_reg    <= {hwdata_in[`MODE_HIGH_BIT], hwdata_in[`MODE_LOW_BIT]}; // RULE10
				drom_en_reg <= hwdata_in[`DROM_EN_BIT];
			end
		end
	end

	// Map mode follows the mode register; software changes take a timed delay
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			map_mode_reg   <= `MODE_SINGLE;
			pend_mode_reg  <= `MODE_SINGLE;
			remap_cnt_reg  <= 4'h0;
			remap_pend_reg <= 1'b0;
		end else begin
			if (!strap_done_reg) begin
				map_mode_reg <= {pin_high_s2_reg, pin_low_s2_reg};
			end else if (state_reg == ST_DONE) begin
				map_mode_reg   <= `MODE_SINGLE; // RULE21
				remap_pend_reg <= 1'b0;
			end else if (wr_mode) begin
				pend_mode_reg  <= {hwdata_in[`MODE_HIGH_BIT], hwdata_in[`MODE_LOW_BIT]};
				remap_cnt_reg  <= REMAP_COUNT;
				remap_pend_reg <= 1'b1;
			end else if (remap_pend_reg) begin
				if (remap_cnt_reg == 4'h1) begin
					map_mode_reg   <= pend_mode_reg; // RULE10 RULE19 RULE20
					remap_pend_reg <= 1'b0;
				end
				remap_cnt_reg <= remap_cnt_reg - 4'h1;
			end
		end
	end

	// X, Y and program space decode, and reset vector
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			x_select_out      <= XS_RAM;
			y_select_out      <= 2'h0;
			p_select_out      <= PS_RAM;
			boot_rom_addr_out <= 5'h00;
			reset_vector_out  <= `RESET_VEC_LOW;
		end else begin
			if (x_address_bus_in >= `X_PERIPH_BASE) begin
				x_select_out <= XS_PER; // RULE3
			end else if (x_address_bus_in <= `XY_RAM_TOP) begin
				x_select_out <= XS_RAM; // RULE1
			end else if (drom_en_reg && x_address_bus_in <= `XY_ROM_TOP) begin
				x_select_out <= XS_ROM; // RULE2
			end else begin
				x_select_out <= XS_EXT; // RULE1
			end
			if (y_address_bus_in <= `XY_RAM_TOP) begin
				y_select_out <= 2'h0; // RULE4
			end else if (drom_en_reg && y_address_bus_in <= `XY_ROM_TOP) begin
				y_select_out <= 2'h1; // RULE4
			end else begin
				y_select_out <= 2'h3;
			end
			boot_rom_addr_out <= program_address_bus_in[4:0]; // RULE14
			case (map_mode_reg)
			`MODE_BOOT: begin
				// Reads see boot ROM; writes decode to RAM up to 01FF, external above
				if (program_write_in) begin
					p_select_out <= (program_address_bus_in <= `P_RAM_TOP) ? PS_RAM : PS_EXT; // RULE14
				end else begin
					p_select_out <= PS_BOOT; // RULE7 RULE14
				end
			end
			`MODE_DEVELOP: p_select_out <= PS_EXT; // RULE13
			default: begin
				// Vectors sit in the low 64 words of the internal RAM
				p_select_out <= (program_address_bus_in <= `P_RAM_TOP) ? PS_RAM : PS_EXT; // RULE5 RULE6 RULE12
			end
			endcase
			reset_vector_out <= (mode_reg == `MODE_EXPANDED) ? `RESET_VEC_EXP : `RESET_VEC_LOW; // RULE12 RULE13
		end
	end

	// Host byte register and early-exit flag
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			host_byte_valid_reg <= 1'b0;
			host_byte_reg       <= 8'h00;
			ext_byte_valid_reg  <= 1'b0;
			ext_byte_reg        <= 8'h00;
			host_flag_zero_reg  <= 1'b0;
		end else begin
			host_byte_valid_reg <= wr_host && (state_reg == ST_HOST); // RULE17 RULE22
			host_byte_reg       <= hwdata_in[7:0];
			ext_byte_valid_reg  <= wr_ext && (state_reg == ST_EXT) && ext_req_reg;
			ext_byte_reg        <= hwdata_in[7:0];
			if (wr_hctl) begin
				host_flag_zero_reg <= hwdata_in[0] | (host_flag_zero_reg & (state_reg == ST_HOST));
			end else if (state_reg != ST_HOST) begin
				host_flag_zero_reg <= 1'b0;
			end
		end
	end

	// Bytes to words; host sends high first, byte memory low first
	boot_byte_packer packer (
		.clk_in         (clk_in),
		.resetn_in      (resetn_in),
		.clear_in       (!loading),
		.high_first_in  (host_sel_reg),
		.byte_valid_in  (host_byte_valid_reg | ext_byte_valid_reg),
		.byte_in        (host_sel_reg ? host_byte_reg : ext_byte_reg),
		.word_valid_out (word_valid),
		.word_out       (word_data)
	);

	// Loader sequencer
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg        <= ST_IDLE;
			host_sel_reg     <= 1'b0;
			ext_addr_reg     <= `P_BOOT_SELECT;
			word_cnt_reg     <= 9'h000;
			ext_req_reg      <= 1'b0;
			pram_we_out      <= 1'b0;
			pram_addr_out    <= 9'h000;
			pram_data_out    <= 24'h000000;
			core_restart_out <= 1'b0;
			boot_ok_reg      <= 1'b0;
		end else begin
			pram_we_out      <= 1'b0;
			core_restart_out <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (strap_done_reg && map_mode_reg == `MODE_BOOT && !remap_pend_reg) begin
					state_reg    <= ST_PROBE;
					ext_addr_reg <= `P_BOOT_SELECT; // RULE15
					ext_req_reg  <= 1'b1;
					word_cnt_reg <= 9'h000;
				end
			end
			ST_PROBE: begin
				// Selector word at C000: bit 23 of the written data
				if (wr_ext) begin
					host_sel_reg <= ~hwdata_in[23]; // RULE15
					state_reg    <= hwdata_in[23] ? ST_EXT : ST_HOST;
					ext_req_reg  <= hwdata_in[23];
				end
			end
			ST_EXT: begin
				if (ext_byte_valid_reg) begin
					ext_addr_reg <= ext_addr_reg + 16'h0001; // RULE16
					ext_req_reg  <= (ext_addr_reg != `P_EXT_LAST);
				end
				if (word_valid) begin
					pram_we_out   <= 1'b1; // RULE16
					pram_addr_out <= word_cnt_reg;
					pram_data_out <= word_data;
					word_cnt_reg  <= word_cnt_reg + 9'h001;
					if (word_cnt_reg == `P_WORD_LAST) begin
						state_reg <= ST_DONE;
					end
				end
			end
			ST_HOST: begin
				if (word_valid) begin
					pram_we_out   <= 1'b1; // RULE22
					pram_addr_out <= word_cnt_reg;
					pram_data_out <= word_data;
					word_cnt_reg  <= word_cnt_reg + 9'h001;
				end
				if ((word_valid && word_cnt_reg == `P_WORD_LAST) || host_flag_zero_reg) begin
					state_reg <= ST_DONE; // RULE18
				end
			end
			ST_DONE: begin
				core_restart_out <= 1'b1; // RULE18 RULE21
				boot_ok_reg      <= 1'b1;
				ext_req_reg      <= 1'b0;
				state_reg        <= ST_WAIT;
			end
			ST_WAIT: begin
				// Wait for the map to leave bootstrap mode, then return to idle
				if (map_mode_reg != `MODE_BOOT) begin
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule // memory_map_mode_bootstrap

// ===== ext_byte_memory.sv
// Byte-wide external memory model on the far side of the loader
`timescale 1ns/1ps
module ext_byte_memory (
	// Byte address and select
	input  wire [15:0] addr_in,
	input  wire        sel_in,
	// Byte returned
	output logic [7:0] data_out
);
	// Fixed contents; a deselected part shows a changing pattern, not the last byte
	always_comb data_out = sel_in ? (addr_in[7:0] ^ 8'hA5 ^ {addr_in[10:8], 5'h00}) : ~addr_in[7:0];
endmodule // ext_byte_memory

// ===== mmb_checker_asserts.sv
// Concurrent checks on the memory map decode and loader outputs
`timescale 1ns/1ps
module mmb_checker (
	// Clock and reset
	input wire        clk_in,
	input wire        resetn_in,
	// Bus response
	input wire        hreadyout_out,
	input wire        hresp_out,
	// Core buses
	input wire [15:0] x_address_bus_in,
	input wire [15:0] y_address_bus_in,
	input wire [15:0] program_address_bus_in,
	// Decode and loader outputs
	input wire [2:0]  x_select_out,
	input wire [1:0]  y_select_out,
	input wire [4:0]  boot_rom_addr_out,
	input wire [15:0] reset_vector_out,
	input wire        pram_we_out,
	input wire [8:0]  pram_addr_out,
	input wire        core_restart_out
);
	reg [8:0] last_addr_reg;
	reg       seen_reg;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Last stored word address within one load
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_addr_reg <= 9'h000;
			seen_reg <= 1'b0;
		end else if (core_restart_out) begin
			seen_reg <= 1'b0;
		end else if (pram_we_out) begin
			last_addr_reg <= pram_addr_out;
			seen_reg <= 1'b1;
		end
	end
	// Decode relations
	a_xram_low: assert property (resetn_in && x_address_bus_in <= 16'h00FF |=> x_select_out == 3'h0)
		else $error("x ram select wrong");
	a_xperiph_top: assert property (resetn_in && x_address_bus_in >= 16'hFFC0 |=> x_select_out == 3'h2)
		else $error("x peripheral select wrong");
	a_xext_mid: assert property (resetn_in && x_address_bus_in >= 16'h0200 && x_address_bus_in < 16'hFFC0
		|=> x_select_out == 3'h3)
		else $error("x external select wrong");
	a_yram_low: assert property (resetn_in && y_address_bus_in <= 16'h00FF |=> y_select_out == 2'h0)
		else $error("y ram select wrong");
	a_xy_rom_pair: assert property (resetn_in && x_address_bus_in[15:8] == 8'h01 && y_address_bus_in[15:8] == 8'h01
		|=> (x_select_out == 3'h1) == (y_select_out == 2'h1))
		else $error("x and y rom enable disagree");
	a_boot_addr_low: assert property (resetn_in |=> boot_rom_addr_out == $past(program_address_bus_in[4:0]))
		else $error("boot rom address wrong");
	a_vector_legal: assert property (reset_vector_out == 16'h0000 || reset_vector_out == 16'hE000)
		else $error("reset vector illegal");
	// Loader and bus response relations
	a_restart_one: assert property (core_restart_out |=> !core_restart_out)
		else $error("restart pulse too long");
	a_word_gap: assert property (pram_we_out |=> !pram_we_out [*2])
		else $error("program words too close");
	a_word_step: assert property (pram_we_out |-> pram_addr_out == (seen_reg ? last_addr_reg + 9'h001 : 9'h000))
		else $error("program word address out of order");
	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus response not ready okay");
endmodule // mmb_checker

bind memory_map_mode_bootstrap mmb_checker chk (.clk_in, .resetn_in, .hreadyout_out, .hresp_out,
	.x_address_bus_in, .y_address_bus_in, .program_address_bus_in, .x_select_out, .y_select_out,
	.boot_rom_addr_out, .reset_vector_out, .pram_we_out, .pram_addr_out, .core_restart_out);

// ===== memory_map_mode_bootstrap_tb.sv
// Self-checking bench for the memory map, mode control and bootstrap loader
`timescale 1ns/1ps
module memory_map_mode_bootstrap_tb;
	localparam logic [2:0]  MODES [6]  = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	localparam logic [15:0] CORNER [6] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'hFFC0, 16'hFFBF};
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0]  htrans_in = 2'h0;
	logic        hwrite_in = 1'b0;
	logic [31:0] hwdata_in = 32'h0;
	logic [15:0] x_address_bus_in = 16'h0;
	logic [15:0] y_address_bus_in = 16'h0;
	logic [15:0] program_address_bus_in = 16'h0;
	logic        program_write_in = 1'b0;
	logic        mode_pin_low_in = 1'b0;
	logic        mode_pin_high_in = 1'b1;
	wire  [31:0] hrdata_out;
	wire         hreadyout_out, hresp_out, interrupt_request_a_out, interrupt_request_b_out;
	wire  [2:0]  x_select_out, p_select_out;
	wire  [1:0]  y_select_out;
	wire  [4:0]  boot_rom_addr_out;
	wire  [15:0] reset_vector_out;
	wire         pram_we_out, core_restart_out;
	wire  [8:0]  pram_addr_out;
	wire  [23:0] pram_data_out;
	wire  [7:0]  mem_data;
	logic [15:0] mem_addr = 16'h0;
	logic [31:0] rv, rs = 32'h6E2C;
	logic [23:0] hw [0:7];
	logic        host = 1'b0;
	int          bad_count = 0, checks = 0, words = 0, restarts = 0;

	// Clock
	always #5 clk_in = ~clk_in;
	memory_map_mode_bootstrap uut (.clk_in, .resetn_in, .hsel_in(1'b1), .haddr_in, .htrans_in, .hwrite_in,
		.hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
		.mode_pin_low_in, .mode_pin_high_in, .interrupt_request_a_out, .interrupt_request_b_out,
		.x_address_bus_in, .y_address_bus_in, .program_address_bus_in, .program_write_in, .x_select_out,
		.y_select_out, .p_select_out, .boot_rom_addr_out, .reset_vector_out, .pram_we_out, .pram_addr_out,
		.pram_data_out, .core_restart_out);
	ext_byte_memory mem (.addr_in(mem_addr), .sel_in(!host), .data_out(mem_data));

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [7:0] eb(input logic [15:0] a);
		return a[7:0] ^ 8'hA5 ^ {a[10:8], 5'h00};
	endfunction
	function automatic logic [2:0] xs(input logic [15:0] a, input logic de);
		if (a <= 16'h00FF) return 3'h0;
		if (a <= 16'h01FF && de) return 3'h1;
		if (a >= 16'hFFC0) return 3'h2;
		return 3'h3;
	endfunction
	function automatic logic [15:0] pick();
		logic [31:0] r;
		r = rnd();
		return (r[2:0] < 3'h6) ? CORNER[r[2:0]] : r[31:16];
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer; read data lands in rv
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		haddr_in <= {24'h000000, a};
		hwrite_in <= w;
		htrans_in <= 2'h2;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		rv = hrdata_out;
	endtask
	task automatic decode(input logic [1:0] m, input logic de);
		repeat (20) begin
			@(posedge clk_in);
			x_address_bus_in <= pick();
			y_address_bus_in <= pick();
			program_address_bus_in <= pick();
			repeat (2) @(posedge clk_in);
			chk(x_select_out, xs(x_address_bus_in, de));
			chk(y_select_out, (xs(y_address_bus_in, de) == 3'h2) ? 3'h3 : xs(y_address_bus_in, de));
			chk(p_select_out, (m == 2'h3 || program_address_bus_in > 16'h01FF) ? 3'h2 : 3'h0);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Stored words and restart pulses from the loader
	always @(posedge clk_in) begin
		if (pram_we_out === 1'b1) begin
			chk(pram_addr_out, words);
			chk(pram_data_out, host ? hw[words] : {eb(16'hC002 + 3 * words), eb(16'hC001 + 3 * words),
				eb(16'hC000 + 3 * words)});
			words++;
		end
		if (core_restart_out === 1'b1) restarts++;
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_in);
		bad_count++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk(reset_vector_out, 16'hE000);
		bus(1'b0, 8'h00, 0);
		chk(rv[1:0], 2'h2);
		mode_pin_low_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk({interrupt_request_b_out, interrupt_request_a_out}, 2'h3);
		bus(1'b0, 8'h00, 0);
		chk(rv[1:0], 2'h2);
		$display("strap test done");
		foreach (MODES[k]) begin
			bus(1'b1, 8'h00, {29'h0, MODES[k]});
			repeat (8) @(posedge clk_in);
			bus(1'b0, 8'h00, 0);
			chk(rv[2:0], MODES[k]);
			chk(reset_vector_out, (MODES[k][1:0] == 2'h2) ? 16'hE000 : 16'h0000);
			decode(MODES[k][1:0], MODES[k][2]);
			$display("map test %0d done", k);
		end
		// Software boot entry, host-port load ended early
		program_address_bus_in <= 16'h0025;
		bus(1'b1, 8'h00, 32'h1);
		chk(p_select_out, 3'h2);
		repeat (3) @(posedge clk_in);
		chk(p_select_out, 3'h2);
		repeat (5) @(posedge clk_in);
		chk(p_select_out, 3'h1);
		chk(boot_rom_addr_out, 5'h05);
		program_write_in <= 1'b1;
		program_address_bus_in <= 16'h0100;
		repeat (3) @(posedge clk_in);
		chk(p_select_out, 3'h0);
		program_write_in <= 1'b0;
		program_address_bus_in <= 16'h0025;
		host = 1'b1;
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b0, 8'h04, 0);
		chk(rv[8], 1'b1);
		for (int i = 0; i < 5; i++) begin
			hw[i] = 24'(rnd());
			for (int b = 2; b >= 0; b--) begin
				repeat (rnd() % 3) @(posedge clk_in);
				bus(1'b1, 8'h08, {24'h0, hw[i][8 * b +: 8]});
			end
		end
		bus(1'b1, 8'h08, 32'h5A);
		bus(1'b1, 8'h0C, 32'h1);
		repeat (20) @(posedge clk_in);
		chk(words, 5);
		chk(restarts, 1);
		bus(1'b0, 8'h00, 0);
		chk(rv[1:0], 2'h0);
		bus(1'b1, 8'h0C, 32'h0);
		$display("host load test done");
		// Boot entry abandoned by a write of mode 2
		bus(1'b1, 8'h00, 32'h1);
		repeat (8) @(posedge clk_in);
		bus(1'b1, 8'h00, 32'h2);
		chk(p_select_out, 3'h1);
		repeat (3) @(posedge clk_in);
		chk(p_select_out, 3'h1);
		repeat (5) @(posedge clk_in);
		chk(p_select_out, 3'h0);
		chk(reset_vector_out, 16'hE000);
		$display("boot exit test done");
		// Strap into boot mode, full load from byte memory
		resetn_in <= 1'b0;
		mode_pin_high_in <= 1'b0;
		host = 1'b0;
		words = 0;
		restarts = 0;
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		bus(1'b1, 8'h14, {8'h00, eb(16'hC002), eb(16'hC001), eb(16'hC000)});
		for (int n = 0; n < 1536; n++) begin
			do bus(1'b0, 8'h14, 0); while (rv[0] !== 1'b1);
			bus(1'b0, 8'h10, 0);
			chk(rv[15:0], 16'hC000 + n);
			mem_addr = rv[15:0];
			repeat (rnd() % 3) @(posedge clk_in);
			#1;
			bus(1'b1, 8'h14, {24'h0, mem_data});
		end
		repeat (20) @(posedge clk_in);
		chk(words, 512);
		chk(restarts, 1);
		bus(1'b0, 8'h04, 0);
		chk(rv[9], 1'b1);
		chk(reset_vector_out, 16'h0000);
		$display("byte memory load test done");
		give_verdict();
	end
endmodule // memory_map_mode_bootstrap_tb
